// File: logic/clf_pkg.sv
/*
 * Shared constants and types for the local-fault supervision block of a
 * high-speed bus transceiver.
 * Assumes a single 100 MHz system clock and no software-visible registers.
 */
package clf_pkg;

    // Clock period of the supervision logic.
    localparam int CLK_PERIOD_NS = 10;

    // Bus dominant timeout; the figure is a plain default, trim per product.
    localparam int BUS_DOM_TIMEOUT_US = 500;
    localparam int BUS_DOM_TIMEOUT_CYC = (BUS_DOM_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

    // Cycles the short signature must persist before it is believed.
    localparam int SHORT_CONFIRM_CYC = 2;

    // Operating modes presented by the mode pins.
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_LISTEN = 2'h1;
    localparam logic [1:0] MODE_STANDBY = 2'h2;

    // Layout of the synchronised pin vector.
    localparam int SYNC_W = 6;
    localparam int SYNC_TXD = 0;
    localparam int SYNC_RXD_PIN = 1;
    localparam int SYNC_BUS_DOM = 2;
    localparam int SYNC_OT = 3;
    localparam int SYNC_MODE_LO = 4;
    // Reset: transmit and receive pins recessive, bus recessive, cool, standby.
    localparam logic [SYNC_W-1:0] SYNC_RST = 6'h23;

    typedef struct packed {
        logic txd_short;
        logic bus_clamp;
        logic over_temp;
    } clf_fault_t;

    localparam clf_fault_t FAULT_RST = 3'h0;

    typedef enum logic {
        CLF_ERR_HIDDEN,
        CLF_ERR_SHOW
    } clf_err_state_t;

endpackage

// File: logic/clf_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to clk; a change is accepted once the
 * second and third stages agree.
 */
`timescale 1ns/1ps
module clf_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    for (genvar i = 0; i < W; i++) begin : g_bit
        wire agree = (s2[i] == s3[i]);
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                s1[i] <= RST_VAL[i];
                s2[i] <= RST_VAL[i];
                s3[i] <= RST_VAL[i];
                dout[i] <= RST_VAL[i];
            end else if (ce) begin
                s1[i] <= din[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (agree) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule // clf_sync

// File: logic/clf_monitor.sv
/*
 * Local-fault supervision: transmit/receive short, bus dominant clamp and
 * over-temperature, with transmitter gating and error-pin reporting.
 * Assumes all pin inputs are asynchronous and pass clf_sync; the analog
 * receiver gives bus_dominant and the thermal sensor gives over_temp with
 * its own hysteresis already applied.
 */
`timescale 1ns/1ps
// Summary of operation
// - Transmit/receive pin short seen on first dominant bit sets flag, disables transmitter.
// - Bus dominant longer than the bus dominant timeout sets the flag.
// - The bus clamp fault leaves the transmitter enabled.
// - Bus clamp flag clears as soon as the bus goes recessive.
// - Over-temperature indication sets the flag.
// - Over-temperature disables transmitter until temperature drops and flag clears.
// - Receive dominant with transmit recessive clears flag and re-enables transmitter.
// - In listen mode the error pin goes high when the flag clears.
// - Entering normal mode from any other mode clears the flag.
// - Error pin driven low for a set flag when entering listen from normal.
// - The flag is the OR of all fault conditions.
module clf_monitor
    import clf_pkg::*;
#(
    parameter int CNT_W = 24,
    parameter int BUS_DOM_CYC = clf_pkg::BUS_DOM_TIMEOUT_CYC
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Controller pins and mode
    input wire logic txd,
    input wire logic rxd_pin,
    input wire logic [1:0] mode,
    // Analog indications
    input wire logic bus_dominant,
    input wire logic over_temp,
    // Outputs
    output logic rxd,
    output logic tx_dominant,
    output logic tx_enable,
    output logic local_fail,
    output logic err_b
);
    import clf_pkg::*;

    logic [SYNC_W-1:0] s_pins;
    logic [1:0] prev_mode;
    logic [1:0] short_cnt;
    logic [CNT_W-1:0] dom_cnt;
    clf_fault_t fault;
    clf_fault_t next_fault;
    clf_err_state_t err_state;
    clf_err_state_t next_err_state;

    clf_sync #(
        .W(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .din({mode, over_temp, bus_dominant, rxd_pin, txd}),
        .dout(s_pins)
    );

    wire s_txd = s_pins[SYNC_TXD];
    wire s_bus_dom = s_pins[SYNC_BUS_DOM];
    wire s_ot = s_pins[SYNC_OT];
    wire [1:0] s_mode = s_pins[SYNC_MODE_LO +: 2];
    wire txd_dom = ~s_txd;
    wire rxd_pin_dom = ~s_pins[SYNC_RXD_PIN];

    // A shorted pair shows the receive pin low before the bus itself has turned
    // dominant; the confirm count rides out skew between the synchronisers.
    wire short_cond = txd_dom & rxd_pin_dom & ~s_bus_dom;
    wire short_hit = short_cond & (short_cnt == 2'(SHORT_CONFIRM_CYC - 1));
    wire clamp_active = s_bus_dom & (dom_cnt == CNT_W'(BUS_DOM_CYC));
    wire enter_normal = (s_mode == MODE_NORMAL) & (prev_mode != MODE_NORMAL);
    wire recover = s_bus_dom & s_txd & ~clamp_active & ~s_ot;
    wire clr_all = recover | enter_normal;

    // Set always wins over any clear in the same cycle.
    wire clf_fault_t fault_set = '{txd_short: short_hit, bus_clamp: clamp_active, over_temp: s_ot};
    wire clf_fault_t fault_clr = '{txd_short: clr_all, bus_clamp: clr_all | ~s_bus_dom,
                                   over_temp: clr_all};
    assign next_fault = fault_set | (fault & ~fault_clr);
    wire next_fail = |next_fault;

    // Only the short and the heat fault gate the transmitter; the clamp does not.
    wire dis_set = short_hit | s_ot;
    wire next_tx_enable = ~dis_set & (tx_enable | ~next_fail);

    wire in_listen = (s_mode == MODE_LISTEN);
    wire listen_from_normal = in_listen & (prev_mode == MODE_NORMAL);
    assign next_err_state = !in_listen ? CLF_ERR_HIDDEN :
                            listen_from_normal ? CLF_ERR_SHOW : err_state;
    wire next_err_b = ~((next_err_state == CLF_ERR_SHOW) & next_fail);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            short_cnt <= 2'h0;
            dom_cnt <= '0;
            prev_mode <= MODE_STANDBY;
        end else if (ce) begin
            short_cnt <= short_cond && !short_hit ? short_cnt + 2'h1 : 2'h0;
            dom_cnt <= !s_bus_dom ? '0 : clamp_active ? dom_cnt : dom_cnt + CNT_W'(1);
            prev_mode <= s_mode;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault <= FAULT_RST;
            local_fail <= 1'b0;
            tx_enable <= 1'b1;
            err_state <= CLF_ERR_HIDDEN;
            err_b <= 1'b1;
        end else if (ce) begin
            fault <= next_fault;
            local_fail <= next_fail;
            tx_enable <= next_tx_enable;
            err_state <= next_err_state;
            err_b <= next_err_b;
        end
    end

    // Receive output mirrors the bus; transmitter drive is gated by the enable.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxd <= 1'b1;
            tx_dominant <= 1'b0;
        end else if (ce) begin
            rxd <= ~s_bus_dom;
            tx_dominant <= txd_dom & next_tx_enable;
        end
    end

    property p_short_sets;
        @(posedge clk) disable iff (!rst_b)
        (ce && short_hit) |=> (local_fail && fault.txd_short && !tx_enable && !tx_dominant);
    endproperty
    a_short_sets: assert property (p_short_sets) else $error("short did not set flag and gate driver");

    property p_clamp_sets;
        @(posedge clk) disable iff (!rst_b)
        (ce && clamp_active) |=> (fault.bus_clamp && local_fail);
    endproperty
    a_clamp_sets: assert property (p_clamp_sets) else $error("bus clamp did not set flag");

    property p_clamp_keeps_tx;
        @(posedge clk) disable iff (!rst_b)
        (ce && clamp_active && tx_enable && !short_hit && !s_ot) |=> tx_enable;
    endproperty
    a_clamp_keeps_tx: assert property (p_clamp_keeps_tx) else $error("bus clamp disabled driver");

    property p_clamp_clears;
        @(posedge clk) disable iff (!rst_b)
        (ce && fault.bus_clamp && !s_bus_dom) |=> !fault.bus_clamp;
    endproperty
    a_clamp_clears: assert property (p_clamp_clears) else $error("clamp flag stuck after recessive");

    property p_ot_sets;
        @(posedge clk) disable iff (!rst_b)
        (ce && s_ot) |=> (local_fail && fault.over_temp && !tx_enable);
    endproperty
    a_ot_sets: assert property (p_ot_sets) else $error("heat fault not flagged");

    property p_ot_holds;
        @(posedge clk) disable iff (!rst_b)
        (!tx_enable && s_ot) |=> !tx_enable;
    endproperty
    a_ot_holds: assert property (p_ot_holds) else $error("driver enabled while hot");

    property p_recover;
        @(posedge clk) disable iff (!rst_b)
        (ce && recover) |=> (!local_fail && tx_enable);
    endproperty
    a_recover: assert property (p_recover) else $error("recovery did not clear flag");

    property p_err_tracks;
        @(posedge clk) disable iff (!rst_b)
        (err_state == CLF_ERR_SHOW) |-> (err_b == !local_fail);
    endproperty
    a_err_tracks: assert property (p_err_tracks) else $error("error pin not tracking flag");

    property p_enter_normal;
        @(posedge clk) disable iff (!rst_b)
        (ce && enter_normal && !s_ot && !clamp_active && !short_hit) |=> !local_fail;
    endproperty
    a_enter_normal: assert property (p_enter_normal) else $error("normal entry kept flag");

    property p_err_hidden;
        @(posedge clk) disable iff (!rst_b)
        (err_state == CLF_ERR_HIDDEN) |-> err_b;
    endproperty
    a_err_hidden: assert property (p_err_hidden) else $error("error pin low outside report");

    // Checked from the detectors rather than the fault vector, so a lost bit in the OR still shows up.
    property p_flag_is_or;
        @(posedge clk) disable iff (!rst_b)
        (ce && (short_hit || clamp_active || s_ot)) |=> local_fail;
    endproperty
    a_flag_is_or: assert property (p_flag_is_or) else $error("single fault did not set flag");

    property p_txen_rise;
        @(posedge clk) disable iff (!rst_b)
        $rose(tx_enable) |-> !local_fail;
    endproperty
    a_txen_rise: assert property (p_txen_rise) else $error("driver enabled with flag set");

    c_short: cover property (@(posedge clk) disable iff (!rst_b) ce && short_hit);
    c_clamp_clear: cover property (@(posedge clk) disable iff (!rst_b) fault.bus_clamp ##1 !fault.bus_clamp);
    c_ot: cover property (@(posedge clk) disable iff (!rst_b) $fell(s_ot) ##[1:50] tx_enable);
    c_err_show: cover property (@(posedge clk) disable iff (!rst_b) !err_b ##[1:100] err_b);
endmodule // clf_monitor

// File: verif/clf_ctrl_model.sv
/*
 * Behavioural protocol controller that drives the transmit and mode pins.
 * Assumes the bench calls its tasks from one process tied to clk.
 */
`timescale 1ns/1ps
module clf_ctrl_model (
    // Clock
    input wire logic clk,
    // Error pin from the monitor
    input wire logic err_b,
    // Pins towards the monitor
    output logic txd,
    output logic [1:0] mode
);
    import clf_pkg::*;

    initial begin
        txd = 1'h1;
        mode = MODE_NORMAL;
    end

    // Every pin level is held for 8 cycles, since narrow levels can be lost.
    task automatic set_txd(input logic val);
        @(posedge clk);
        txd <= val;
        repeat (8) @(posedge clk);
    endtask

    task automatic set_mode(input logic [1:0] val);
        @(posedge clk);
        mode <= val;
        repeat (8) @(posedge clk);
        #1;
    endtask

    // Read the flag in listen mode, then go back to normal to clear it.
    task automatic read_flag(output logic seen);
        set_mode(MODE_LISTEN);
        seen = ~err_b;
        set_mode(MODE_NORMAL);
    endtask
endmodule // clf_ctrl_model

// File: verif/can_local_fault_monitor_test.sv
/*
 * Self-checking bench for the local-fault monitor.
 * Assumes the controller model drives the transmit and mode pins.
 */
`timescale 1ns/1ps
module can_local_fault_monitor_test;
    import clf_pkg::*;
    logic clk, rst_b, ce, rxd_pin, bus_dominant, over_temp, txd, f;
    logic [1:0] mode;
    logic rxd, tx_dominant, tx_enable, local_fail, err_b;
    int bad_count, checks_done;
    int cycles = 0;

    // A short timeout keeps the clamp scenario brief.
    clf_monitor #(.BUS_DOM_CYC(20)) dut (
        .clk(clk), .rst_b(rst_b), .ce(ce), .txd(txd), .rxd_pin(rxd_pin),
        .mode(mode), .bus_dominant(bus_dominant), .over_temp(over_temp),
        .rxd(rxd), .tx_dominant(tx_dominant), .tx_enable(tx_enable),
        .local_fail(local_fail), .err_b(err_b));
    clf_ctrl_model u_ctrl (.clk(clk), .err_b(err_b), .txd(txd), .mode(mode));

    task automatic check(input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic pins(input logic r, input logic b, input logic t, input int n);
        @(posedge clk);
        rxd_pin <= r;
        bus_dominant <= b;
        over_temp <= t;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic test_short();
        pins(1'h0, 1'h0, 1'h0, 1);
        u_ctrl.set_txd(1'h0);
        #1;
        check(local_fail, 1'h1);
        check(tx_enable, 1'h0);
        check(tx_dominant, 1'h0);
        u_ctrl.set_mode(MODE_LISTEN);
        check(err_b, 1'h0);
        u_ctrl.set_txd(1'h1);
        pins(1'h1, 1'h1, 1'h0, 8);
        check(local_fail, 1'h0);
        check(tx_enable, 1'h1);
        check(err_b, 1'h1);
        check(rxd, 1'h0);
        pins(1'h1, 1'h0, 1'h0, 1);
        u_ctrl.set_mode(MODE_NORMAL);
        $display("test short done");
    endtask

    task automatic test_clamp();
        pins(1'h1, 1'h1, 1'h0, 10);
        check(local_fail, 1'h0);
        pins(1'h1, 1'h1, 1'h0, 20);
        check(local_fail, 1'h1);
        u_ctrl.set_txd(1'h0);
        #1;
        check(tx_enable, 1'h1);
        check(tx_dominant, 1'h1);
        u_ctrl.set_txd(1'h1);
        pins(1'h1, 1'h0, 1'h0, 8);
        check(local_fail, 1'h0);
        $display("test clamp done");
    endtask

    task automatic test_heat();
        pins(1'h1, 1'h0, 1'h1, 8);
        check(local_fail, 1'h1);
        check(tx_enable, 1'h0);
        u_ctrl.read_flag(f);
        check(local_fail, 1'h1);
        pins(1'h1, 1'h0, 1'h0, 8);
        check(tx_enable, 1'h0);
        u_ctrl.read_flag(f);
        check(f, 1'h1);
        check(local_fail, 1'h0);
        check(tx_enable, 1'h1);
        u_ctrl.read_flag(f);
        check(f, 1'h0);
        $display("test heat done");
    endtask

    // A frozen block must ignore the heat pin, then catch up once enabled again.
    task automatic test_freeze();
        @(posedge clk);
        ce <= 1'h0;
        pins(1'h1, 1'h0, 1'h1, 8);
        check(local_fail, 1'h0);
        check(tx_enable, 1'h1);
        @(posedge clk);
        ce <= 1'h1;
        repeat (8) @(posedge clk);
        #1;
        check(local_fail, 1'h1);
        check(tx_enable, 1'h0);
        u_ctrl.set_mode(MODE_STANDBY);
        u_ctrl.set_mode(MODE_LISTEN);
        check(err_b, 1'h1);
        check(local_fail, 1'h1);
        pins(1'h1, 1'h0, 1'h0, 8);
        check(tx_enable, 1'h0);
        u_ctrl.set_mode(MODE_NORMAL);
        check(local_fail, 1'h0);
        check(tx_enable, 1'h1);
        $display("test freeze done");
    endtask

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // The whole run needs well under a thousand cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        rst_b = 1'h0;
        ce = 1'h1;
        rxd_pin = 1'h1;
        bus_dominant = 1'h0;
        over_temp = 1'h0;
        bad_count = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        #1;
        check(rxd, 1'h1);
        check(tx_dominant, 1'h0);
        check(tx_enable, 1'h1);
        check(local_fail, 1'h0);
        check(err_b, 1'h1);
        $display("test reset done");
        test_short();
        test_clamp();
        test_heat();
        test_freeze();
        stop_test();
    end
endmodule // can_local_fault_monitor_test
